//--- diag_pkg.sv
// constants shared by the diagnostic word encoder files
package diag_pkg;
    // widths
    localparam int DIAG_W = 32;
    localparam int ADDR_W = 8;
    localparam int IRQ_W = 4;
    localparam int DUAL_W = 4;
    localparam int TEST_SIG_W = 8;
    localparam int OUT_W = 4;

    // module type codes
    localparam logic [7:0] MOD_SECURE_IO = 8'h02;
    localparam logic [7:0] MOD_GW_A = 8'h03;
    localparam logic [7:0] MOD_GW_B = 8'h04;
    localparam logic [7:0] MOD_GW_C = 8'h05;
    localparam logic [7:0] MOD_RSV_A = 8'h06;
    localparam logic [7:0] MOD_RSV_B = 8'h07;

    // diagnostic bit positions
    localparam int BIT_SELFTEST = 1;
    localparam int BIT_CONFIG = 4;
    localparam int BIT_OUT_SUPPLY = 5;
    localparam int BIT_IN_STATE = 5;
    localparam int BIT_OUT_STATE = 6;
    localparam int BIT_DUAL_BASE = 8;
    localparam int BIT_TEST_SIG_BASE = 16;
    localparam int BIT_SHORT_BASE = 24;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DIAG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_SENT = 8'h10;

    // control fields and reset
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_INDEX_LSB = 8;
    localparam int CTRL_EN_BIT = 16;
    localparam int CTRL_SEND_BIT = 17;
    localparam logic [7:0] CODE_RESET = 8'h02;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic EN_RESET = 1'b1;

    // interrupt bits and reset
    localparam int IRQ_CHANGE = 0;
    localparam int IRQ_NEW_FAULT = 1;
    localparam int IRQ_SENT = 2;
    localparam int IRQ_MISSED = 3;
    localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_OFFER = 1'b1
    } emcy_state_e;
endpackage

//--- diag_word_map.sv
// maps detector flags onto the 32-bit diagnostic word per module type
`timescale 1ns/1ps
`default_nettype none
module diag_word_map
    import diag_pkg::*;
(
    // selection
    input wire logic [7:0] code_i,
    // detector flags
    input wire logic selftest_fail_i,
    input wire logic config_invalid_i,
    input wire logic out_supply_fault_i,
    input wire logic [DUAL_W-1:0] dual_chan_err_i,
    input wire logic [TEST_SIG_W-1:0] test_sig_fault_i,
    input wire logic [OUT_W-1:0] short_high_i,
    input wire logic [OUT_W-1:0] short_low_i,
    input wire logic in_data_state_i,
    input wire logic out_data_state_i,
    // word
    output logic [DIAG_W-1:0] word_o
);
    logic [DIAG_W-1:0] secure_word;

    // short pairs: after high even, after low odd
    genvar g;
    generate
        for (g = 0; g < OUT_W; g++) begin : g_short
            assign secure_word[BIT_SHORT_BASE+2*g] = short_high_i[g];
            assign secure_word[BIT_SHORT_BASE+2*g+1] = short_low_i[g];
        end
    endgenerate

    assign secure_word[BIT_TEST_SIG_BASE+:TEST_SIG_W] = test_sig_fault_i;
    assign secure_word[15:12] = 4'h0;
    assign secure_word[BIT_DUAL_BASE+:DUAL_W] = dual_chan_err_i;
    assign secure_word[7:6] = 2'h0;
    assign secure_word[BIT_OUT_SUPPLY] = out_supply_fault_i;
    assign secure_word[BIT_CONFIG] = config_invalid_i;
    assign secure_word[3:2] = 2'h0;
    assign secure_word[BIT_SELFTEST] = selftest_fail_i;
    assign secure_word[0] = 1'b0;

    always_comb begin
        word_o = '0;
        case (code_i)
            MOD_SECURE_IO: begin
                word_o = secure_word;
            end
            MOD_GW_A, MOD_GW_B, MOD_GW_C: begin
                word_o[BIT_SELFTEST] = selftest_fail_i;
                word_o[BIT_CONFIG] = config_invalid_i;
                word_o[BIT_IN_STATE] = in_data_state_i;
                word_o[BIT_OUT_STATE] = out_data_state_i;
            end
            MOD_RSV_A, MOD_RSV_B: begin
                word_o[BIT_SELFTEST] = selftest_fail_i;
                word_o[BIT_CONFIG] = config_invalid_i;
            end
            default: begin
                word_o = '0;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- diag_irq_regs.sv
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
`default_nettype none
module diag_irq_regs #(
    parameter int W = 4,
    parameter logic [W-1:0] MASK_INIT = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // events and software access
    input wire logic [W-1:0] event_i,
    input wire logic [W-1:0] clear_i,
    input wire logic mask_wr_i,
    input wire logic [W-1:0] mask_data_i,
    // state
    output logic [W-1:0] status_o,
    output logic [W-1:0] mask_o,
    output logic irq_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // set wins over clear
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status_o[g] <= 1'b0;
                end else begin
                    status_o[g] <= event_i[g] | (status_o[g] & ~clear_i[g]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_o <= MASK_INIT;
        end else if (mask_wr_i) begin
            mask_o <= mask_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_o & mask_o);
        end
    end
endmodule
`default_nettype wire

//--- diag_status_encoder.sv
// emergency diagnostic word encoder with wishbone registers
//
// How it works
// - secure io type sets bit 1 when internal self-tests failed.
// - every described type sets bit 4 on invalid configuration.
// - secure io type sets bit 5 while output supply out of range.
// - secure io type bits 8 to 11 flag input pair discrepancy.
// - secure io type bits 16 to 23 flag test signal faults.
// - secure io bits 24 to 31 flag output shorts, high then low.
// - gateway types use bit 5 for input data state.
// - gateway types use bit 6 for output data state.
// - bit 0 lands in bottom byte bit 0, bit 31 in top bit 7.
// - all four state bytes are active high.
// - faulting module index byte precedes the four state bytes.
`timescale 1ns/1ps
`default_nettype none
module diag_status_encoder
    import diag_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [diag_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // fault detectors
    input wire logic SELFTEST_FAIL_I,
    input wire logic CONFIG_INVALID_I,
    input wire logic OUT_SUPPLY_FAULT_I,
    input wire logic [diag_pkg::DUAL_W-1:0] DUAL_CHAN_ERR_I,
    input wire logic [diag_pkg::TEST_SIG_W-1:0] TEST_SIG_FAULT_I,
    input wire logic [diag_pkg::OUT_W-1:0] SHORT_HIGH_I,
    input wire logic [diag_pkg::OUT_W-1:0] SHORT_LOW_I,
    input wire logic IN_DATA_STATE_I,
    input wire logic OUT_DATA_STATE_I,
    // emergency framer
    input wire logic EMCY_READY_I,
    output logic EMCY_VALID_O,
    output logic [7:0] FAULTING_MODULE_INDEX_O,
    output logic [7:0] DIAG_STATE_BYTE_TOP_O,
    output logic [7:0] DIAG_STATE_BYTE_UPPER_MID_O,
    output logic [7:0] DIAG_STATE_BYTE_LOWER_MID_O,
    output logic [7:0] DIAG_STATE_BYTE_BOTTOM_O,
    // interrupt
    output logic IRQ_O
);
    import diag_pkg::*;

    // control register fields
    logic [7:0] module_code;
    logic [7:0] module_index;
    logic encode_en;
    logic send_req;

    // diagnostic word path
    logic [DIAG_W-1:0] mapped_word;
    logic [DIAG_W-1:0] diag_word;
    logic [DIAG_W-1:0] sent_word;
    logic [DIAG_W-1:0] next_diag_word;
    logic [7:0] state_byte [4];

    // message handshake
    emcy_state_e state;
    emcy_state_e next_state;
    logic launch;
    logic handed_over;
    logic word_changed;
    logic fault_added;
    logic word_moving;

    // bus decode
    logic bus_req;
    logic wr_strobe;
    logic rd_strobe;
    logic [31:0] next_rdata;
    logic ctrl_wr;
    logic status_wr;
    logic send_wr;
    logic [31:0] lane_data;

    // interrupt block
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq_level;
    logic mask_wr;

    // byte lane merge helper
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i+:8] = new_val[8*i+:8];
            end
        end
        return res;
    endfunction

    // word mapping per module type
    diag_word_map u_map (
        .code_i(module_code),
        .selftest_fail_i(SELFTEST_FAIL_I),
        .config_invalid_i(CONFIG_INVALID_I),
        .out_supply_fault_i(OUT_SUPPLY_FAULT_I),
        .dual_chan_err_i(DUAL_CHAN_ERR_I),
        .test_sig_fault_i(TEST_SIG_FAULT_I),
        .short_high_i(SHORT_HIGH_I),
        .short_low_i(SHORT_LOW_I),
        .in_data_state_i(IN_DATA_STATE_I),
        .out_data_state_i(OUT_DATA_STATE_I),
        .word_o(mapped_word)
    );

    // bus request qualification
    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_strobe = bus_req & WB_WE_I;
    assign rd_strobe = bus_req & ~WB_WE_I;

    // per-register write strobes
    assign ctrl_wr = wr_strobe && WB_ADR_I == REG_CTRL;
    assign status_wr = wr_strobe && WB_ADR_I == REG_IRQ_STATUS;
    assign send_wr = ctrl_wr && WB_SEL_I[2] && WB_DAT_I[CTRL_SEND_BIT];
    assign lane_data = merge_lanes(32'h0000_0000, WB_DAT_I, WB_SEL_I);

    // acknowledge one cycle after request, dropped next cycle
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req;
        end
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (WB_ADR_I)
            REG_CTRL: begin
                next_rdata[CTRL_CODE_LSB+:8] = module_code;
                next_rdata[CTRL_INDEX_LSB+:8] = module_index;
                next_rdata[CTRL_EN_BIT] = encode_en;
            end
            REG_DIAG: begin
                next_rdata = diag_word;
            end
            REG_IRQ_STATUS: begin
                next_rdata[IRQ_W-1:0] = irq_status;
            end
            REG_IRQ_MASK: begin
                next_rdata[IRQ_W-1:0] = irq_mask;
            end
            REG_SENT: begin
                next_rdata = sent_word;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data register
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (rd_strobe) begin
            WB_DAT_O <= next_rdata;
        end
    end

    // module code, lane 0
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            module_code <= CODE_RESET;
        end else if (ctrl_wr && WB_SEL_I[0]) begin
            module_code <= WB_DAT_I[CTRL_CODE_LSB+:8];
        end
    end

    // module index, lane 1
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            module_index <= INDEX_RESET;
        end else if (ctrl_wr && WB_SEL_I[1]) begin
            module_index <= WB_DAT_I[CTRL_INDEX_LSB+:8];
        end
    end

    // encode enable, lane 2
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            encode_en <= EN_RESET;
        end else if (ctrl_wr && WB_SEL_I[2]) begin
            encode_en <= WB_DAT_I[CTRL_EN_BIT];
        end
    end

    // one-shot resend request, cleared once launched
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            send_req <= 1'b0;
        end else if (send_wr) begin
            send_req <= 1'b1;
        end else if (launch) begin
            send_req <= 1'b0;
        end
    end

    // current word, zero while encoding is off
    assign next_diag_word = encode_en ? mapped_word : '0;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            diag_word <= '0;
        end else begin
            diag_word <= next_diag_word;
        end
    end

    // handshake toward the framer
    assign word_changed = diag_word != sent_word;
    assign launch = (state == ST_IDLE) & (word_changed | send_req);
    assign handed_over = (state == ST_OFFER) & EMCY_READY_I;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (launch) begin
                    next_state = ST_OFFER;
                end
            end
            ST_OFFER: begin
                if (EMCY_READY_I) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            EMCY_VALID_O <= 1'b0;
        end else begin
            EMCY_VALID_O <= (next_state == ST_OFFER);
        end
    end

    // index byte captured at launch
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            FAULTING_MODULE_INDEX_O <= 8'h00;
        end else if (launch) begin
            FAULTING_MODULE_INDEX_O <= module_index;
        end
    end

    // last offered word
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sent_word <= '0;
        end else if (launch) begin
            sent_word <= diag_word;
        end
    end

    // message bytes captured at launch, stable while offered
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_byte
            always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    state_byte[b] <= 8'h00;
                end else if (launch) begin
                    state_byte[b] <= diag_word[8*b+:8];
                end
            end
        end
    endgenerate

    // byte k of the word, counted from the bottom
    assign DIAG_STATE_BYTE_BOTTOM_O = state_byte[0];
    assign DIAG_STATE_BYTE_LOWER_MID_O = state_byte[1];
    assign DIAG_STATE_BYTE_UPPER_MID_O = state_byte[2];
    assign DIAG_STATE_BYTE_TOP_O = state_byte[3];

    // event terms
    assign fault_added = |(diag_word & ~sent_word);
    assign word_moving = next_diag_word != diag_word;

    // interrupt events
    always_comb begin
        irq_event = '0;
        irq_event[IRQ_CHANGE] = launch & word_changed;
        irq_event[IRQ_NEW_FAULT] = launch & fault_added;
        irq_event[IRQ_SENT] = handed_over;
        irq_event[IRQ_MISSED] = (state == ST_OFFER) & word_moving;
    end

    assign irq_clear = (status_wr && WB_SEL_I[0])
                       ? WB_DAT_I[IRQ_W-1:0] : '0;
    assign mask_wr = wr_strobe && WB_ADR_I == REG_IRQ_MASK && WB_SEL_I[0];

    diag_irq_regs #(
        .W(IRQ_W),
        .MASK_INIT(MASK_RESET)
    ) u_irq (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .event_i(irq_event),
        .clear_i(irq_clear),
        .mask_wr_i(mask_wr),
        .mask_data_i(lane_data[IRQ_W-1:0]),
        .status_o(irq_status),
        .mask_o(irq_mask),
        .irq_o(irq_level)
    );

    assign IRQ_O = irq_level;
endmodule
`default_nettype wire

//--- diag_status_encoder_sva.sv
// checker for the diagnostic word encoder ports
`timescale 1ns/1ps
`default_nettype none
module diag_status_encoder_sva (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // wishbone
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // emergency framer
    input wire logic EMCY_READY_I,
    input wire logic EMCY_VALID_O,
    input wire logic [7:0] FAULTING_MODULE_INDEX_O,
    input wire logic [7:0] DIAG_STATE_BYTE_TOP_O,
    input wire logic [7:0] DIAG_STATE_BYTE_UPPER_MID_O,
    input wire logic [7:0] DIAG_STATE_BYTE_LOWER_MID_O,
    input wire logic [7:0] DIAG_STATE_BYTE_BOTTOM_O,
    // interrupt
    input wire logic IRQ_O
);
    logic taken;
    logic mask_set;
    assign taken = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mask_set <= 1'b0;
        end else if (taken && WB_WE_I && WB_ADR_I == 8'h0c && WB_SEL_I[0]
                     && WB_DAT_I[3:0] != 4'h0) begin
            mask_set <= 1'b1;
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_bytes_hold;
        EMCY_VALID_O && !EMCY_READY_I |=> EMCY_VALID_O
            && $stable({DIAG_STATE_BYTE_TOP_O, DIAG_STATE_BYTE_UPPER_MID_O,
            DIAG_STATE_BYTE_LOWER_MID_O, DIAG_STATE_BYTE_BOTTOM_O});
    endproperty
    a_bytes_hold: assert property (p_bytes_hold)
        else $error("state bytes moved while offered");
    property p_index_hold;
        EMCY_VALID_O && !EMCY_READY_I |=> $stable(FAULTING_MODULE_INDEX_O);
    endproperty
    a_index_hold: assert property (p_index_hold)
        else $error("index byte moved while offered");
    property p_valid_drop;
        EMCY_VALID_O && EMCY_READY_I |=> !EMCY_VALID_O;
    endproperty
    a_valid_drop: assert property (p_valid_drop)
        else $error("valid held after handover");
    property p_ack_answer;
        taken |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("bus ack not a single pulse after request");
    property p_ack_no_req;
        !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O;
    endproperty
    a_ack_no_req: assert property (p_ack_no_req)
        else $error("ack without request");
    property p_unmapped;
        taken && !WB_WE_I && !(WB_ADR_I inside {8'h00, 8'h04, 8'h08,
            8'h0c, 8'h10}) |=> WB_DAT_O == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rsv_low;
        EMCY_VALID_O |-> (DIAG_STATE_BYTE_BOTTOM_O & 8'h8d) == 8'h00
            && DIAG_STATE_BYTE_LOWER_MID_O[7:4] == 4'h0;
    endproperty
    a_rsv_low: assert property (p_rsv_low)
        else $error("reserved bit set");
    property p_bit6_excl;
        EMCY_VALID_O && {DIAG_STATE_BYTE_TOP_O, DIAG_STATE_BYTE_UPPER_MID_O,
            DIAG_STATE_BYTE_LOWER_MID_O} != 24'h0
            |-> !DIAG_STATE_BYTE_BOTTOM_O[6];
    endproperty
    a_bit6_excl: assert property (p_bit6_excl)
        else $error("gateway bit beside secure io bits");
    property p_irq_masked;
        !mask_set |-> !IRQ_O;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with all sources masked");
endmodule
`default_nettype wire

//--- emcy_framer_model.sv
// behavioural emergency framer that takes offered messages
`timescale 1ns/1ps
`default_nettype none
module emcy_framer_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // offered message
    input wire logic valid_i,
    input wire logic [39:0] msg_i,
    input wire logic [7:0] delay_i,
    // handshake and capture
    output logic ready_o,
    output logic got_o,
    output logic [39:0] cap_o
);
    logic [7:0] cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 8'h00;
            ready_o <= 1'b0;
            got_o <= 1'b0;
            cap_o <= '0;
        end else begin
            got_o <= 1'b0;
            if (valid_i && ready_o) begin
                ready_o <= 1'b0;
                cnt <= 8'h00;
                got_o <= 1'b1;
                // index byte ahead of the state bytes
                cap_o <= msg_i;
            end else if (valid_i) begin
                cnt <= cnt + 8'h01;
                ready_o <= (cnt >= delay_i);
            end
        end
    end
endmodule
`default_nettype wire

//--- diag_status_encoder_tb.sv
// self-checking bench for the diagnostic word encoder
`timescale 1ns/1ps
`default_nettype none
module diag_status_encoder_tb;
    import diag_pkg::*;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0, dly = 0;
    logic [31:0] dat = 0, rdat, f = 0, seed = 32'h32, q;
    logic ack, vld, rdy, got, irq;
    logic [39:0] msg, cap;
    logic [39:0] notes[$];
    int miscompares = 0, n_tests = 0;
    always #2 clk = ~clk;
    diag_status_encoder u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SELFTEST_FAIL_I(f[0]), .CONFIG_INVALID_I(f[1]),
        .OUT_SUPPLY_FAULT_I(f[2]), .DUAL_CHAN_ERR_I(f[6:3]),
        .TEST_SIG_FAULT_I(f[14:7]), .SHORT_HIGH_I(f[18:15]),
        .SHORT_LOW_I(f[22:19]), .IN_DATA_STATE_I(f[23]),
        .OUT_DATA_STATE_I(f[24]), .EMCY_READY_I(rdy), .EMCY_VALID_O(vld),
        .FAULTING_MODULE_INDEX_O(msg[39:32]),
        .DIAG_STATE_BYTE_TOP_O(msg[31:24]),
        .DIAG_STATE_BYTE_UPPER_MID_O(msg[23:16]),
        .DIAG_STATE_BYTE_LOWER_MID_O(msg[15:8]),
        .DIAG_STATE_BYTE_BOTTOM_O(msg[7:0]), .IRQ_O(irq));
    emcy_framer_model u_far (.clk_i(clk), .rst_n_i(rst_n), .valid_i(vld),
        .msg_i(msg), .delay_i(dly), .ready_o(rdy), .got_o(got),
        .cap_o(cap));
    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] ew(input logic [7:0] c,
                                       input logic [31:0] r);
        logic [31:0] w;
        w = '0;
        if (c >= 8'h02 && c <= 8'h07) begin
            w[1] = r[0];
            w[4] = r[1];
        end
        if (c == 8'h02) begin
            w[5] = r[2];
            w[11:8] = r[6:3];
            w[23:16] = r[14:7];
            for (int n = 0; n < 4; n++) begin
                w[24+2*n] = r[15+n];
                w[25+2*n] = r[19+n];
            end
        end
        if (c >= 8'h03 && c <= 8'h05) begin
            w[5] = r[23];
            w[6] = r[24];
        end
        return w;
    endfunction
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        if (ack !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic drain;
        int i;
        i = 0;
        while (notes.size() != 0 && i < 500) begin
            @(posedge clk);
            i++;
        end
        if (notes.size() != 0) begin
            miscompares++;
            finish_test();
        end
    endtask
    task automatic apply(input logic [31:0] r);
        @(posedge clk);
        f <= r;
    endtask
    always @(posedge clk) begin
        if (got) begin
            if (notes.size() == 0) check(cap, ~cap);
            else check(cap, notes.pop_front());
        end
    end
    initial begin
        logic [31:0] e;
        logic [31:0] r;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, REG_CTRL, 32'h0);
        check({8'h0, q}, 40'h0000010002);
        wb(1'b0, 8'h14, 32'h0);
        check({8'h0, q}, 40'h0);
        wb(1'b1, REG_IRQ_MASK, 32'h4);
        for (int c = 2; c <= 8; c++) begin
            wb(1'b1, REG_CTRL, {15'h0, 1'b1, 8'(c + 8'h40), 8'(c)});
            seed = xs(seed);
            r = seed | 32'h1;
            e = ew(8'(c), r);
            if (e != 0) notes.push_back({8'(c + 8'h40), e});
            apply(r);
            drain();
            wb(1'b0, REG_DIAG, 32'h0);
            check({8'h0, q}, {8'h0, e});
            if (e != 0) notes.push_back({8'(c + 8'h40), 32'h0});
            apply(32'h0);
            drain();
        end
        check({39'h0, irq}, 40'h1);
        wb(1'b1, REG_IRQ_STATUS, 32'hf);
        repeat (2) @(posedge clk);
        check({39'h0, irq}, 40'h0);
        dly <= 8'd20;
        wb(1'b1, REG_CTRL, 32'h00010702);
        seed = xs(seed);
        r = seed | 32'h1;
        notes.push_back({8'h07, ew(8'h02, r)});
        notes.push_back({8'h07, ew(8'h02, r ^ 32'h2)});
        apply(r);
        repeat (5) @(posedge clk);
        apply(r ^ 32'h2);
        drain();
        wb(1'b0, REG_IRQ_STATUS, 32'h0);
        check({36'h0, q[3:0]}, 40'hf);
        notes.push_back({8'h07, 32'h0});
        apply(32'h0);
        drain();
        notes.push_back({8'h05, 32'h0});
        wb(1'b1, REG_CTRL, 32'h00020507);
        apply(seed | 32'h1);
        drain();
        wb(1'b0, REG_DIAG, 32'h0);
        check({8'h0, q}, 40'h0);
        wb(1'b0, REG_CTRL, 32'h0);
        check({8'h0, q}, 40'h0000000507);
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule
bind diag_status_encoder diag_status_encoder_sva u_sva (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .EMCY_READY_I(EMCY_READY_I),
    .EMCY_VALID_O(EMCY_VALID_O),
    .FAULTING_MODULE_INDEX_O(FAULTING_MODULE_INDEX_O),
    .DIAG_STATE_BYTE_TOP_O(DIAG_STATE_BYTE_TOP_O),
    .DIAG_STATE_BYTE_UPPER_MID_O(DIAG_STATE_BYTE_UPPER_MID_O),
    .DIAG_STATE_BYTE_LOWER_MID_O(DIAG_STATE_BYTE_LOWER_MID_O),
    .DIAG_STATE_BYTE_BOTTOM_O(DIAG_STATE_BYTE_BOTTOM_O), .IRQ_O(IRQ_O));
`default_nettype wire
